// >>> hdl/divide_and_multiply_hold_sequencer.v
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
`include "hold_seq_consts.vh"

module divide_and_multiply_hold_sequencer #(
   parameter LF_DIV = `LF_DIV
) (
   input wire ref_clk_in,
   input wire reset_in,
   input wire [`ADDR_W-1:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   output reg [31:0] reg_rdata_out,
   input wire [`WORD_W-1:0] storage_bus_in,
   output reg [`WORD_W-1:0] storage_bus_out,
   output reg storage_bus_strobe_out,
   output reg main_control_hold_out,
   output reg alarm_out,
   output reg busy_out
);

   // ------------------------------------------------------------
   // main control states
   // ------------------------------------------------------------
   localparam S_IDLE = 4'h0;
   localparam S_CLEAR = 4'h1;
   localparam S_READ_BUS = 4'h2;
   localparam S_ACC_SIGN = 4'h3;
   localparam S_TO_B = 4'h4;
   localparam S_CLR_ACC = 4'h5;
   localparam S_OPA_SIGN = 4'h6;
   localparam S_MUL_LOOP = 4'h7;
   localparam S_CARRY = 4'h8;
   localparam S_ROUND = 4'h9;
   localparam S_PROD_SIGN = 4'hA;
   localparam S_CLR_B = 4'hB;
   localparam S_SUBTRACT = 4'hC;
   localparam S_DIV_LOOP = 4'hD;
   localparam S_TO_BUS = 4'hE;
   localparam S_ALARM = 4'hF;

   // ones' complement sum with end-around carry
   function [`WORD_W-1:0] oc_add;
      input [`WORD_W-1:0] a;
      input [`WORD_W-1:0] b;
      reg [`WORD_W:0] raw;
      begin
         raw = {1'b0, a} + {1'b0, b};
         oc_add = raw[`WORD_W-1:0] + {{(`WORD_W-1){1'b0}}, raw[`WORD_W]};
      end
   endfunction

   reg [3:0] state_ff, nxt_state;
   reg [`ORDER_W-1:0] order_ff, nxt_order;
   reg [`WORD_W-1:0] accumulator_reg_ff, nxt_accumulator_reg;
   reg [`WORD_W-1:0] operand_a_reg_ff, nxt_operand_a_reg;
   reg [`WORD_W-1:0] operand_b_reg_ff, nxt_operand_b_reg;
   reg sign_control_flop_ff, nxt_sign_control_flop;
   reg divide_run_flop_ff, nxt_divide_run_flop;
   reg divide_phase_flop_ff, nxt_divide_phase_flop;
   reg divide_error_flop_ff, nxt_divide_error_flop;
   reg mul_run_ff, nxt_mul_run;
   reg pend_carry_ff, nxt_pend_carry;
   reg [`STEP_W-1:0] step_ff, nxt_step;
   reg [15:0] lf_cnt_ff;
   reg lf_tick_ff;
   reg [`WORD_W:0] raw_sum;
   reg [`WORD_W-1:0] shifted;
   reg ejected;

   wire accumulator_sign_bit = accumulator_reg_ff[`SIGN_BIT];
   wire accumulator_lsb = accumulator_reg_ff[0];
   wire operand_b_msb = operand_b_reg_ff[`SIGN_BIT];
   wire divide_clock_gate = divide_run_flop_ff & lf_tick_ff;
   wire divide_carry_gate = divide_clock_gate & ~divide_phase_flop_ff;
   wire divide_shift_gate = divide_clock_gate & divide_phase_flop_ff;
   wire divide_alarm_gate = divide_error_flop_ff;
   wire order_write = reg_write_in && (reg_addr_in == `OFS_ORDER);
   wire idle = (state_ff == S_IDLE);

   // ------------------------------------------------------------
   // low-frequency pulse source for the divide distributor
   // ------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         lf_cnt_ff <= 16'h0000;
         lf_tick_ff <= 1'b0;
      end else if (lf_cnt_ff == LF_DIV[15:0] - 16'h0001) begin
         lf_cnt_ff <= 16'h0000;
         lf_tick_ff <= 1'b1;
      end else begin
         lf_cnt_ff <= lf_cnt_ff + 16'h0001;
         lf_tick_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // main control and arithmetic element next values
   // ------------------------------------------------------------
   always @* begin
      nxt_state = state_ff;
      nxt_order = order_ff;
      nxt_accumulator_reg = accumulator_reg_ff;
      nxt_operand_a_reg = operand_a_reg_ff;
      nxt_operand_b_reg = operand_b_reg_ff;
      nxt_sign_control_flop = sign_control_flop_ff;
      nxt_divide_run_flop = divide_run_flop_ff;
      nxt_divide_phase_flop = divide_phase_flop_ff;
      nxt_divide_error_flop = divide_error_flop_ff;
      nxt_mul_run = mul_run_ff;
      nxt_pend_carry = pend_carry_ff;
      nxt_step = step_ff;
      raw_sum = {(`WORD_W+1){1'b0}};
      shifted = `WORD_ZERO;
      ejected = 1'b0;
      case (state_ff)
         S_IDLE: begin
            if (order_write) begin
               nxt_order = reg_wdata_in[`ORDER_W-1:0];
               case (reg_wdata_in[`ORDER_W-1:0])
                  `ORD_MUL_ROUND, `ORD_MUL_FULL, `ORD_DIVIDE: nxt_state = S_CLEAR;
                  `ORD_TO_STORE: nxt_state = S_TO_BUS;
                  default: nxt_state = S_IDLE;
               endcase
            end else if (reg_write_in && reg_addr_in == `OFS_ACC) begin
               nxt_accumulator_reg = reg_wdata_in[`WORD_W-1:0];
            end
         end
         // multiply clears A and B, divide clears A only
         S_CLEAR: begin
            nxt_operand_a_reg = `WORD_ZERO;
            if (order_ff != `ORD_DIVIDE) begin
               nxt_operand_b_reg = `WORD_ZERO;
            end
            nxt_state = S_READ_BUS;
         end
         S_READ_BUS: begin
            nxt_operand_a_reg = storage_bus_in;
            nxt_state = S_ACC_SIGN;
         end
         // make accumulator positive, remember the sign, arm overflow check
         S_ACC_SIGN: begin
            if (accumulator_sign_bit) begin
               nxt_accumulator_reg = ~accumulator_reg_ff;
               nxt_sign_control_flop = ~sign_control_flop_ff;
            end
            nxt_divide_error_flop = 1'b1;
            nxt_state = (order_ff == `ORD_DIVIDE) ? S_OPA_SIGN : S_TO_B;
         end
         S_TO_B: begin
            nxt_operand_b_reg = accumulator_reg_ff;
            nxt_state = S_CLR_ACC;
         end
         S_CLR_ACC: begin
            nxt_accumulator_reg = `WORD_ZERO;
            nxt_state = (order_ff == `ORD_DIVIDE) ? S_PROD_SIGN : S_OPA_SIGN;
         end
         // make A-operand positive, toggling the sign memory
         S_OPA_SIGN: begin
            if (operand_a_reg_ff[`SIGN_BIT]) begin
               nxt_operand_a_reg = ~operand_a_reg_ff;
               nxt_sign_control_flop = ~sign_control_flop_ff;
            end
            if (order_ff == `ORD_DIVIDE) begin
               nxt_state = S_SUBTRACT;
            end else begin
               nxt_state = S_MUL_LOOP;
               nxt_mul_run = 1'b1;
               nxt_step = `STEP_ZERO;
            end
         end
         // high-frequency multiply: one add or one shift per cycle
         S_MUL_LOOP: begin
            if (operand_b_reg_ff[0]) begin
               nxt_accumulator_reg = oc_add(accumulator_reg_ff, operand_a_reg_ff);
               nxt_operand_b_reg = {operand_b_reg_ff[`WORD_W-1:1], 1'b0};
            end else begin
               nxt_accumulator_reg = {1'b0, accumulator_reg_ff[`WORD_W-1:1]};
               nxt_operand_b_reg = {accumulator_lsb, operand_b_reg_ff[`WORD_W-1:1]};
               nxt_step = step_ff + 5'h01;
               if (step_ff == `MUL_STEPS - 1) begin
                  nxt_mul_run = 1'b0;
                  nxt_state = S_CARRY;
               end
            end
         end
         // rounding multiply rounds and clears B; full product skips both
         S_CARRY: begin
            nxt_state = (order_ff == `ORD_MUL_ROUND) ? S_ROUND : S_PROD_SIGN;
         end
         S_ROUND: begin
            if (operand_b_msb) begin
               nxt_accumulator_reg = oc_add(accumulator_reg_ff, `WORD_ONE);
            end
            nxt_state = S_PROD_SIGN;
         end
         S_PROD_SIGN: begin
            if (sign_control_flop_ff) begin
               nxt_accumulator_reg = ~accumulator_reg_ff;
            end
            nxt_sign_control_flop = 1'b0;
            nxt_state = (order_ff == `ORD_MUL_ROUND) ? S_CLR_B : S_IDLE;
         end
         S_CLR_B: begin
            nxt_operand_b_reg = `WORD_ZERO;
            nxt_state = S_IDLE;
         end
         // initial subtraction; its end-around carry waits for the loop carry
         S_SUBTRACT: begin
            raw_sum = {1'b0, accumulator_reg_ff} + {1'b0, ~operand_a_reg_ff};
            nxt_accumulator_reg = raw_sum[`WORD_W-1:0];
            nxt_pend_carry = raw_sum[`WORD_W];
            nxt_divide_run_flop = 1'b1;
            nxt_divide_phase_flop = 1'b0;
            nxt_step = `STEP_ZERO;
            nxt_state = S_DIV_LOOP;
         end
         // low-frequency divide distributor
         S_DIV_LOOP: begin
            if (divide_carry_gate) begin
               nxt_accumulator_reg = accumulator_reg_ff + {{(`WORD_W-1){1'b0}}, pend_carry_ff};
               nxt_pend_carry = 1'b0;
               nxt_step = step_ff + 5'h01;
               nxt_divide_phase_flop = 1'b1;
            end else if (divide_shift_gate) begin
               ejected = accumulator_sign_bit;
               shifted = {accumulator_reg_ff[`WORD_W-2:0], ejected};
               if (ejected) begin
                  raw_sum = {1'b0, shifted} + {1'b0, operand_a_reg_ff};
               end else begin
                  raw_sum = {1'b0, shifted} + {1'b0, ~operand_a_reg_ff};
               end
               nxt_accumulator_reg = raw_sum[`WORD_W-1:0];
               nxt_pend_carry = raw_sum[`WORD_W];
               nxt_operand_b_reg = {operand_b_msb, operand_b_reg_ff[`WORD_W-3:0], ~ejected};
               nxt_divide_phase_flop = 1'b0;
               if (divide_alarm_gate) begin
                  nxt_divide_error_flop = 1'b0;
                  if (!ejected) begin
                     nxt_divide_run_flop = 1'b0;
                     nxt_state = S_ALARM;
                  end
               end
               if ((divide_alarm_gate && !ejected) == 1'b0 && step_ff == `DIV_STEPS) begin
                  nxt_divide_run_flop = 1'b0;
                  nxt_state = S_CLR_ACC;
               end
            end
         end
         S_TO_BUS: begin
            nxt_state = S_IDLE;
         end
         // clock stopped until software clears the alarm
         S_ALARM: begin
            if (reg_write_in && reg_addr_in == `OFS_STATUS && reg_wdata_in[`ST_ALARM_CLR]) begin
               nxt_state = S_IDLE;
               nxt_sign_control_flop = 1'b0; // aborted divide must not leave a stale sign
            end
         end
         default: nxt_state = S_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         state_ff <= S_IDLE;
         order_ff <= `ORD_NONE;
         accumulator_reg_ff <= `WORD_ZERO;
         operand_a_reg_ff <= `WORD_ZERO;
         operand_b_reg_ff <= `WORD_ZERO;
         sign_control_flop_ff <= 1'b0;
         divide_run_flop_ff <= 1'b0;
         divide_phase_flop_ff <= 1'b0;
         divide_error_flop_ff <= 1'b0;
         mul_run_ff <= 1'b0;
         pend_carry_ff <= 1'b0;
         step_ff <= `STEP_ZERO;
      end else begin
         state_ff <= nxt_state;
         order_ff <= nxt_order;
         accumulator_reg_ff <= nxt_accumulator_reg;
         operand_a_reg_ff <= nxt_operand_a_reg;
         operand_b_reg_ff <= nxt_operand_b_reg;
         sign_control_flop_ff <= nxt_sign_control_flop;
         divide_run_flop_ff <= nxt_divide_run_flop;
         divide_phase_flop_ff <= nxt_divide_phase_flop;
         divide_error_flop_ff <= nxt_divide_error_flop;
         mul_run_ff <= nxt_mul_run;
         pend_carry_ff <= nxt_pend_carry;
         step_ff <= nxt_step;
      end
   end

   // ------------------------------------------------------------
   // registered outputs: bus drive, hold, alarm, busy
   // ------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         storage_bus_out <= `WORD_ZERO;
         storage_bus_strobe_out <= 1'b0;
         main_control_hold_out <= 1'b0;
         alarm_out <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         storage_bus_strobe_out <= (state_ff == S_TO_BUS);
         if (state_ff == S_TO_BUS) begin
            storage_bus_out <= accumulator_reg_ff;
         end
         main_control_hold_out <= nxt_mul_run | nxt_divide_run_flop;
         alarm_out <= (nxt_state == S_ALARM);
         busy_out <= (nxt_state != S_IDLE);
      end
   end

   // ------------------------------------------------------------
   // register read port, data one cycle after the strobe
   // ------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         reg_rdata_out <= 32'h00000000;
      end else if (reg_read_in) begin
         case (reg_addr_in)
            `OFS_ORDER: reg_rdata_out <= {29'h00000000, order_ff};
            `OFS_STATUS: reg_rdata_out <= {25'h0000000, main_control_hold_out, mul_run_ff,
               divide_run_flop_ff, divide_error_flop_ff, sign_control_flop_ff, alarm_out, ~idle};
            `OFS_ACC: reg_rdata_out <= {16'h0000, accumulator_reg_ff};
            `OFS_OPB: reg_rdata_out <= {16'h0000, operand_b_reg_ff};
            `OFS_OPA: reg_rdata_out <= {16'h0000, operand_a_reg_ff};
            `OFS_STEP: reg_rdata_out <= {27'h0000000, step_ff};
            default: reg_rdata_out <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_out <= 32'h00000000;
      end
   end

endmodule // divide_and_multiply_hold_sequencer

// >>> inc/hold_seq_consts.vh
`ifndef HOLD_SEQ_CONSTS_VH
`define HOLD_SEQ_CONSTS_VH

// ------------------------------------------------------------
// word layout
// ------------------------------------------------------------
`define WORD_W 16
`define SIGN_BIT 15
`define WORD_ZERO 16'h0000
`define WORD_ONE 16'h0001

// ------------------------------------------------------------
// register offsets (byte addresses on the register port)
// ------------------------------------------------------------
`define ADDR_W 8
`define OFS_ORDER 8'h00
`define OFS_STATUS 8'h04
`define OFS_ACC 8'h08
`define OFS_OPB 8'h0C
`define OFS_OPA 8'h10
`define OFS_STEP 8'h14

// ------------------------------------------------------------
// order codes written to the order register
// ------------------------------------------------------------
`define ORDER_W 3
`define ORD_NONE 3'h0
`define ORD_MUL_ROUND 3'h1
`define ORD_MUL_FULL 3'h2
`define ORD_DIVIDE 3'h3
`define ORD_TO_STORE 3'h4

// ------------------------------------------------------------
// status bit positions
// ------------------------------------------------------------
`define ST_BUSY 0
`define ST_ALARM 1
`define ST_SIGN_CTL 2
`define ST_DIV_ERR 3
`define ST_DIV_RUN 4
`define ST_MUL_RUN 5
`define ST_HOLD 6
`define ST_ALARM_CLR 0

// ------------------------------------------------------------
// step counts and timing
// ------------------------------------------------------------
`define STEP_W 5
`define STEP_ZERO 5'h00
`define MUL_STEPS 15
`define DIV_STEPS 17
`define LF_DIV 4

`endif

// >>> tb/divide_and_multiply_hold_sequencer_tb_top.sv
`timescale 1ns/100ps
`include "hold_seq_consts.vh"

module divide_and_multiply_hold_sequencer_tb_top;
   typedef struct packed {logic [2:0] ord; logic [15:0] acc; logic [15:0] bus;
      logic [15:0] eacc; logic [15:0] eb; logic [15:0] mask; logic [4:0] estep;} row_t;
   logic ref_clk_in = 1'b0, reset_in = 1'b1, reg_write_in = 1'b0, reg_read_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
   logic [15:0] storage_bus_in, storage_bus_out, bus_word = 16'h0000, stored;
   logic storage_bus_strobe_out, main_control_hold_out, alarm_out, busy_out;
   logic [7:0] store_count;
   logic [31:0] d;
   integer err_count = 0, total_checks = 0, i, n;
   row_t rows [0:6];

   always #5 ref_clk_in = ~ref_clk_in;

   divide_and_multiply_hold_sequencer #(.LF_DIV(2)) divide_and_multiply_hold_sequencer_i (
      .ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
      .storage_bus_in(storage_bus_in), .storage_bus_out(storage_bus_out),
      .storage_bus_strobe_out(storage_bus_strobe_out), .main_control_hold_out(main_control_hold_out),
      .alarm_out(alarm_out), .busy_out(busy_out));
   storage_model storage_model_i (.ref_clk_in(ref_clk_in), .word_in(bus_word), .busy_in(busy_out),
      .strobe_in(storage_bus_strobe_out), .bus_in(storage_bus_out), .bus_out(storage_bus_in),
      .stored_out(stored), .store_count_out(store_count));

   // ------------------------------------------------------------
   // reference arithmetic
   // ------------------------------------------------------------
   function automatic logic [15:0] oc_add(input logic [15:0] x, input logic [15:0] y);
      logic [16:0] s;
      s = x + y;
      return s[15:0] + s[16];
   endfunction
   // non-restoring divide of magnitudes, digits after the two leading ones
   function automatic logic [15:0] div_ref(input logic [15:0] dvd, input logic [15:0] dvs);
      logic [15:0] r, q;
      logic s;
      r = oc_add(dvd, ~dvs);
      q = 16'h0000;
      for (int k = 0; k < 17; k++) begin
         s = r[15];
         r = {r[14:0], s};
         r = s ? oc_add(r, dvs) : oc_add(r, ~dvs);
         q = {q[14:0], ~s};
      end
      return q & 16'h7FFF;
   endfunction

   // ------------------------------------------------------------
   // bus tasks and compares
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_wdata_in <= v;
      reg_write_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_write_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk_in);
      reg_addr_in <= a;
      reg_read_in <= 1'b1;
      @(posedge ref_clk_in);
      reg_read_in <= 1'b0;
      #1 d = reg_rdata_out;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wait_idle;
      n = 0;
      @(posedge ref_clk_in);
      #1;
      while (busy_out !== 1'b0 && n < 3000) begin
         @(posedge ref_clk_in);
         #1 n++;
      end
      chk("busy_out", 32'h0, {31'h0, busy_out});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge ref_clk_in);
      err_count++;
      tally_and_finish();
   end

   initial begin
      rows[0] = '{3'h1, 16'h4001, 16'h4000, 16'h2001, 16'h0000, 16'hFFFF, 5'd15};
      rows[1] = '{3'h2, 16'h4001, 16'h4000, 16'h2000, 16'h8000, 16'hFFFF, 5'd15};
      rows[2] = '{3'h2, 16'hBFFE, 16'h4000, 16'hDFFF, 16'h8000, 16'hFFFF, 5'd15};
      rows[3] = '{3'h1, 16'h4000, 16'hBFFF, 16'hDFFF, 16'h0000, 16'hFFFF, 5'd15};
      rows[4] = '{3'h3, 16'h1000, 16'h6000, 16'h0000, div_ref(16'h1000, 16'h6000), 16'h7FFF, 5'd17};
      rows[5] = '{3'h3, 16'hEFFF, 16'h6000, 16'hFFFF, div_ref(16'h1000, 16'h6000), 16'h7FFF, 5'd17};
      rows[6] = '{3'h3, 16'hD555, 16'hAAAA, 16'h0000, div_ref(16'h2AAA, 16'h5555), 16'h7FFF, 5'd17};
      repeat (4) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      for (i = 0; i < 7; i++) begin
         wr(`OFS_ACC, {16'h0, rows[i].acc});
         bus_word <= rows[i].bus;
         wr(`OFS_ORDER, {29'h0, rows[i].ord});
         wait_idle();
         rd(`OFS_ACC);
         chk("acc", {16'h0, rows[i].eacc}, d);
         rd(`OFS_OPB);
         chk("opb", {16'h0, rows[i].eb}, d & {16'h0, rows[i].mask});
         rd(`OFS_STEP);
         chk("step", {27'h0, rows[i].estep}, d);
         rd(`OFS_STATUS);
         chk("status", {28'h0, rows[i].ord != `ORD_DIVIDE, 3'h0}, d & 32'h0000007F);
         $display("test %0d done", i);
      end
      // transfer keeps the accumulator and strobes the bus once
      n = store_count;
      wr(`OFS_ACC, 32'h0000_1234);
      wr(`OFS_ORDER, {29'h0, `ORD_TO_STORE});
      wait_idle();
      @(posedge ref_clk_in);
      #1 chk("stored", 32'h1234, {16'h0, stored});
      chk("store_count", n + 1, {24'h0, store_count});
      rd(`OFS_ACC);
      chk("acc", 32'h1234, d);
      // accumulator write during a multiply is refused; unmapped places
      wr(`OFS_ACC, 32'h0000_4001);
      bus_word <= 16'h4000;
      wr(`OFS_ORDER, {29'h0, `ORD_MUL_ROUND});
      wr(`OFS_ACC, 32'h0000_7777);
      wr(8'h40, 32'h0000_FFFF);
      wait_idle();
      rd(`OFS_ACC);
      chk("acc", 32'h2001, d);
      rd(8'h40);
      chk("unmapped", 32'h0, d);
      $display("test transfer and refusal done");
      // divide overflow raises a lasting alarm
      wr(`OFS_ACC, 32'h0000_9FFF);
      bus_word <= 16'h2000;
      wr(`OFS_ORDER, {29'h0, `ORD_DIVIDE});
      n = 0;
      while (alarm_out !== 1'b1 && n < 500) begin
         @(posedge ref_clk_in);
         #1 n++;
      end
      repeat (10) @(posedge ref_clk_in);
      #1 chk("alarm_out", 32'h1, {31'h0, alarm_out});
      chk("busy_out", 32'h1, {31'h0, busy_out});
      rd(`OFS_STATUS);
      chk("status_alarm", 32'h1, {31'h0, d[`ST_ALARM]});
      wr(`OFS_STATUS, 32'h0000_0001);
      @(posedge ref_clk_in);
      #1 chk("alarm_out", 32'h0, {31'h0, alarm_out});
      rd(`OFS_STATUS);
      chk("status", 32'h0, d & 32'h0000007F);
      // second reset in mid-run
      wr(`OFS_ACC, 32'h0000_1000);
      wr(`OFS_ORDER, {29'h0, `ORD_DIVIDE});
      repeat (12) @(posedge ref_clk_in);
      reset_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      #1 chk("outputs", 32'h0, {28'h0, busy_out, alarm_out, main_control_hold_out, storage_bus_strobe_out});
      rd(`OFS_ACC);
      chk("acc", 32'h0, d);
      $display("test alarm and reset done");
      tally_and_finish();
   end
endmodule // divide_and_multiply_hold_sequencer_tb_top

// >>> tb/hold_seq_checker.sv
`timescale 1ns/100ps
`include "hold_seq_consts.vh"

module hold_seq_checker #(
   parameter LF_DIV = `LF_DIV
) (
   input wire ref_clk_in,
   input wire reset_in,
   input wire [`ADDR_W-1:0] reg_addr_in,
   input wire [31:0] reg_wdata_in,
   input wire reg_write_in,
   input wire reg_read_in,
   input wire [31:0] reg_rdata_out,
   input wire [`WORD_W-1:0] storage_bus_in,
   input wire [`WORD_W-1:0] storage_bus_out,
   input wire storage_bus_strobe_out,
   input wire main_control_hold_out,
   input wire alarm_out,
   input wire busy_out
);
   localparam int DIV_MIN = 31 * LF_DIV;
   localparam int DIV_MAX = 37 * LF_DIV;
   reg [2:0] mode_ff;
   reg [9:0] hold_cnt_ff;
   wire order_go = reg_write_in && reg_addr_in == `OFS_ORDER && !busy_out;
   wire loop_go = order_go && reg_wdata_in[2:0] >= `ORD_MUL_ROUND && reg_wdata_in[2:0] <= `ORD_DIVIDE;
   wire alarm_clr = reg_write_in && reg_addr_in == `OFS_STATUS && reg_wdata_in[`ST_ALARM_CLR];

   // ------------------------------------------------------------
   // helper logic
   // ------------------------------------------------------------
   // last accepted order and length of the current hold
   always @(posedge ref_clk_in) begin
      if (reset_in) begin
         mode_ff <= `ORD_NONE;
         hold_cnt_ff <= 10'h000;
      end else begin
         if (order_go && reg_wdata_in[2:0] <= `ORD_TO_STORE) mode_ff <= reg_wdata_in[2:0];
         hold_cnt_ff <= main_control_hold_out ? hold_cnt_ff + 10'h001 : 10'h000;
      end
   end

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   ts_strobe_a: assert property (order_go && reg_wdata_in[2:0] == `ORD_TO_STORE |-> ##[1:2] storage_bus_strobe_out)
      else $error("transfer order gave no bus strobe");
   strobe_once_a: assert property (storage_bus_strobe_out |=> !storage_bus_strobe_out)
      else $error("bus strobe longer than one cycle");
   strobe_ts_only_a: assert property (storage_bus_strobe_out |-> mode_ff == `ORD_TO_STORE && !main_control_hold_out)
      else $error("bus strobe outside transfer order");
   hold_busy_a: assert property (main_control_hold_out |-> busy_out)
      else $error("hold without busy");
   hold_start_a: assert property (loop_go |-> ##[4:10] main_control_hold_out)
      else $error("loop did not suspend main control");
   div_len_a: assert property ($fell(main_control_hold_out) && mode_ff == `ORD_DIVIDE |=>
      alarm_out || ($past(hold_cnt_ff) >= DIV_MIN && $past(hold_cnt_ff) <= DIV_MAX))
      else $error("divide loop length wrong");
   mul_len_a: assert property ($fell(main_control_hold_out) && mode_ff != `ORD_DIVIDE |->
      $past(hold_cnt_ff) >= 14 && $past(hold_cnt_ff) <= 32)
      else $error("multiply loop length wrong");
   hold_end_a: assert property ($fell(main_control_hold_out) |=> ##[0:8] (!busy_out || alarm_out))
      else $error("order did not finish after loop");
   alarm_stay_a: assert property (alarm_out && !alarm_clr |=> alarm_out)
      else $error("alarm dropped by itself");
   alarm_busy_a: assert property (alarm_out |-> busy_out)
      else $error("alarm without busy");

   ts_c: cover property (storage_bus_strobe_out);
   div_c: cover property ($fell(main_control_hold_out) && mode_ff == `ORD_DIVIDE);
   mul_c: cover property ($fell(main_control_hold_out) && mode_ff == `ORD_MUL_FULL);
   alarm_c: cover property ($rose(alarm_out));
endmodule // hold_seq_checker

bind divide_and_multiply_hold_sequencer hold_seq_checker #(.LF_DIV(LF_DIV)) hold_seq_checker_i (
   .ref_clk_in(ref_clk_in), .reset_in(reset_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
   .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
   .storage_bus_in(storage_bus_in), .storage_bus_out(storage_bus_out),
   .storage_bus_strobe_out(storage_bus_strobe_out), .main_control_hold_out(main_control_hold_out),
   .alarm_out(alarm_out), .busy_out(busy_out));

// >>> tb/storage_model.sv
`timescale 1ns/100ps

module storage_model (
   input wire ref_clk_in,
   input wire [15:0] word_in,
   input wire busy_in,
   input wire strobe_in,
   input wire [15:0] bus_in,
   output logic [15:0] bus_out,
   output logic [15:0] stored_out,
   output logic [7:0] store_count_out
);
   initial begin
      stored_out = 16'h0000;
      store_count_out = 8'h00;
   end
   // word held during an order, inverse once the bus is released
   always @* bus_out = busy_in ? word_in : ~word_in;
   // stored word for a later program, counted on each bus strobe
   always @(posedge ref_clk_in) begin
      if (strobe_in === 1'b1) begin
         stored_out <= bus_in;
         store_count_out <= store_count_out + 8'h01;
      end
   end
endmodule // storage_model
